/* src/bpg_top.sv */
// Self-test pattern generator that replaces incoming video.
// Assumes panel timing supplies active-area size, pixel position,
// data enable and a frame-start pulse in the pixel clock domain.
`timescale 1ns/10ps
`default_nettype none
module bpg_top
    import bpg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Settings
    input wire logic [3:0] test_pattern_select,
    input wire logic [7:0] white_field_level,
    input wire logic crosstalk_center_colour,
    // Panel timing
    input wire logic [COORD_W-1:0] h_active,
    input wire logic [COORD_W-1:0] v_active,
    input wire logic [COORD_W-1:0] pix_x,
    input wire logic [COORD_W-1:0] pix_y,
    input wire logic pix_de,
    input wire logic frame_start,
    // Pattern pixel out
    output logic [PIX_W-1:0] pat_r,
    output logic [PIX_W-1:0] pat_g,
    output logic [PIX_W-1:0] pat_b,
    output logic pat_de,
    output logic pat_valid
);
    // ==========================================================
    // Pattern selection
    logic [3:0] auto_code;
    logic auto_on;
    logic [3:0] eff_code;
    logic flick_r;
    logic [COORD_W-1:0] cell_w;
    logic [COORD_W-1:0] cell_h;
    logic [COORD_W-1:0] cx_r;
    logic [COORD_W-1:0] cy_r;
    logic chess_x_r;
    logic chess_y_r;
    logic narrow_cell;
    logic [PIX_W-1:0] hramp;
    logic [PIX_W-1:0] vramp;
    logic in_box;
    logic box_white;
    logic [PIX_W-1:0] mono;
    logic [PIX_W-1:0] r_nxt;
    logic [PIX_W-1:0] g_nxt;
    logic [PIX_W-1:0] b_nxt;
    logic valid_nxt;

    // Scales a coordinate onto the 8-bit gray range
    function automatic logic [PIX_W-1:0] ramp_of(
        input logic [COORD_W-1:0] pos,
        input logic [COORD_W-1:0] size);
        logic [COORD_W+PIX_W-1:0] prod;
        prod = {pos, PIX_W'(0)};
        ramp_of = (size == '0) ? BPG_ZERO
                : PIX_W'(prod / {{PIX_W{1'b0}}, size});
    endfunction

    // Black or white level from one bit
    function automatic logic [PIX_W-1:0] bw(input logic on);
        bw = on ? BPG_FULL : BPG_ZERO;
    endfunction

    // auto run selects the sequencer code
    assign auto_on = (test_pattern_select == BPG_AUTO);
    assign eff_code = auto_on ? auto_code : test_pattern_select;

    bpg_auto_seq u_seq (
        .clk(clk),
        .rst(rst),
        .enable(auto_on),
        .frame_start(frame_start),
        .code(auto_code)
    );

    // ==========================================================
    // Chess cell tracking
    // Counters instead of dividers keep the cell test cheap per pixel
    assign cell_w = h_active / COORD_W'(BPG_CHESS_DIV);
    assign cell_h = v_active / COORD_W'(BPG_CHESS_DIV);
    // One-pixel cells have no count phase to wait through
    assign narrow_cell = (cell_w <= COORD_W'(1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cx_r <= '0;
            chess_x_r <= 1'b0;
        end else if (!pix_de) begin
            cx_r <= COORD_W'(1);
            chess_x_r <= 1'b0;
        end else if (pix_x == '0) begin
            // Narrow cells must show the second cell on the next pixel
            cx_r <= COORD_W'(1);
            chess_x_r <= narrow_cell;
        end else if (cx_r >= cell_w - COORD_W'(1)) begin
            cx_r <= '0;
            chess_x_r <= ~chess_x_r;
        end else begin
            cx_r <= cx_r + COORD_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cy_r <= '0;
            chess_y_r <= 1'b0;
        end else if (frame_start) begin
            cy_r <= '0;
            chess_y_r <= 1'b0;
        end else if (pix_de && pix_x == h_active - COORD_W'(1)) begin
            if (cy_r >= cell_h - COORD_W'(1)) begin
                cy_r <= '0;
                chess_y_r <= ~chess_y_r;
            end else begin
                cy_r <= cy_r + COORD_W'(1);
            end
        end
    end

    // Flicker swaps polarity every frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flick_r <= 1'b0;
        end else if (frame_start) begin
            flick_r <= ~flick_r;
        end
    end

    // ==========================================================
    // Per-pixel decode
    // gray ramps follow position
    assign hramp = ramp_of(pix_x, h_active);
    assign vramp = ramp_of(pix_y, v_active);
    // centre box spans the middle half
    assign in_box = (pix_x >= (h_active >> 2))
                 && (pix_x < h_active - (h_active >> 2))
                 && (pix_y >= (v_active >> 2))
                 && (pix_y < v_active - (v_active >> 2));
    assign box_white = in_box ? crosstalk_center_colour
                              : ~crosstalk_center_colour;

    always_comb begin
        mono = BPG_ZERO;
        valid_nxt = 1'b1;
        case (eff_code)
            BPG_WHITE: mono = white_field_level;
            BPG_BLACK: mono = BPG_ZERO;
            BPG_CHESS: mono = bw(chess_x_r ^ chess_y_r);
            BPG_HRAMP: mono = hramp;
            BPG_VRAMP: mono = vramp;
            BPG_GRAY192: mono = BPG_LVL192;
            BPG_XTALK: mono = bw(box_white);
            BPG_HLINES: mono = bw(~pix_y[0]);
            BPG_VLINES: mono = bw(~pix_x[0]);
            BPG_FLICKER: mono = bw(flick_r ^ pix_x[0] ^ pix_y[0]);
            BPG_RED, BPG_GREEN, BPG_BLUE: mono = BPG_FULL;
            default: valid_nxt = 1'b0;
        endcase
    end

    assign r_nxt = (eff_code == BPG_GREEN || eff_code == BPG_BLUE)
                   ? BPG_ZERO : mono;
    assign g_nxt = (eff_code == BPG_RED || eff_code == BPG_BLUE)
                   ? BPG_ZERO : mono;
    assign b_nxt = (eff_code == BPG_RED || eff_code == BPG_GREEN)
                   ? BPG_ZERO : mono;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pat_r <= BPG_ZERO;
            pat_g <= BPG_ZERO;
            pat_b <= BPG_ZERO;
            pat_de <= 1'b0;
            pat_valid <= 1'b0;
        end else begin
            pat_r <= (pix_de && valid_nxt) ? r_nxt : BPG_ZERO;
            pat_g <= (pix_de && valid_nxt) ? g_nxt : BPG_ZERO;
            pat_b <= (pix_de && valid_nxt) ? b_nxt : BPG_ZERO;
            pat_de <= pix_de;
            pat_valid <= valid_nxt;
        end
    end

    // ==========================================================
    // Checks
    // white level passes through
    chk_white_level: assert property (@(posedge clk) disable iff (rst)
        pix_de && test_pattern_select == BPG_WHITE
        |=> pat_r == $past(white_field_level) && pat_g == pat_r
            && pat_b == pat_r) else $error("white level wrong");
    chk_xtalk_center: assert property (@(posedge clk) disable iff (rst)
        pix_de && test_pattern_select == BPG_XTALK && in_box
        |=> pat_g == bw($past(crosstalk_center_colour)))
        else $error("crosstalk centre wrong");
    chk_hlines_alt: assert property (@(posedge clk) disable iff (rst)
        pix_de && test_pattern_select == BPG_HLINES
        |=> pat_r == bw(~$past(pix_y[0]))) else $error("row lines wrong");
    chk_vlines_alt: assert property (@(posedge clk) disable iff (rst)
        pix_de && test_pattern_select == BPG_VLINES
        |=> pat_b == bw(~$past(pix_x[0]))) else $error("col lines wrong");
    chk_ramp_origin: assert property (@(posedge clk) disable iff (rst)
        pix_de && test_pattern_select == BPG_HRAMP && pix_x == '0
        |=> pat_r == BPG_ZERO) else $error("ramp origin wrong");
    chk_reserved_none: assert property (@(posedge clk) disable iff (rst)
        test_pattern_select == BPG_RSV_D || test_pattern_select == BPG_RSV_F
        |=> !pat_valid && pat_r == BPG_ZERO) else $error("reserved drove");
    // red has no green or blue
    chk_red_only: assert property (@(posedge clk) disable iff (rst)
        pix_de && test_pattern_select == BPG_RED
        |=> pat_r == BPG_FULL && pat_g == BPG_ZERO && pat_b == BPG_ZERO)
        else $error("red pattern wrong");
    chk_gray_192: assert property (@(posedge clk) disable iff (rst)
        pix_de && test_pattern_select == BPG_GRAY192
        |=> pat_g == BPG_LVL192) else $error("level 192 wrong");

    cov_auto_mode: cover property (@(posedge clk) disable iff (rst)
        auto_on && pix_de);
    cov_chess_swap: cover property (@(posedge clk) disable iff (rst)
        eff_code == BPG_CHESS && chess_x_r ##1 !chess_x_r);
    cov_flicker: cover property (@(posedge clk) disable iff (rst)
        eff_code == BPG_FLICKER && frame_start);
endmodule
`default_nettype wire

/* include/bpg_pkg.sv */
// Constants for the self-test pattern generator.
// Assumes a pixel datapath of 8 bits per colour and panel timing
// supplied from outside as active-area coordinates.
`default_nettype none
package bpg_pkg;
    localparam int unsigned COORD_W = 12;
    localparam int unsigned PIX_W = 8;
    typedef enum logic [3:0] {
        BPG_WHITE = 4'b0000,
        BPG_BLACK = 4'b0001,
        BPG_RED = 4'b0010,
        BPG_GREEN = 4'b0011,
        BPG_BLUE = 4'b0100,
        BPG_CHESS = 4'b0101,
        BPG_HRAMP = 4'b0110,
        BPG_VRAMP = 4'b0111,
        BPG_GRAY192 = 4'b1000,
        BPG_XTALK = 4'b1001,
        BPG_HLINES = 4'b1010,
        BPG_VLINES = 4'b1011,
        BPG_FLICKER = 4'b1100,
        BPG_RSV_D = 4'b1101,
        BPG_AUTO = 4'b1110,
        BPG_RSV_F = 4'b1111
    } bpg_pat_t;
    localparam logic [3:0] BPG_AUTO_FIRST = 4'h0;
    localparam logic [3:0] BPG_AUTO_LAST = 4'hC;
    localparam logic [7:0] BPG_FULL = 8'hFF;
    localparam logic [7:0] BPG_ZERO = 8'h00;
    localparam logic [7:0] BPG_LVL192 = 8'hC0;
    // Chess cells: 8 by 8 over the active area
    localparam int unsigned BPG_CHESS_DIV = 8;
    // Frames each pattern stays on during auto run
    localparam logic [7:0] BPG_AUTO_FRAMES = 8'h3C;
endpackage
`default_nettype wire

/* src/bpg_auto_seq.sv */
// Auto-run sequencer: steps through codes 0 to 12, then wraps.
// Assumes frame_start is a one-cycle pulse per frame.
`timescale 1ns/10ps
`default_nettype none
module bpg_auto_seq
    import bpg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic enable,
    input wire logic frame_start,
    // Result
    output logic [3:0] code
);
    logic [3:0] code_r;
    logic [3:0] code_nxt;
    logic [7:0] frames_r;
    logic [7:0] frames_nxt;
    logic dwell_done;

    assign dwell_done = (frames_r == BPG_AUTO_FRAMES - 8'h01);
    assign code_nxt = (code_r == BPG_AUTO_LAST) ? BPG_AUTO_FIRST
                                               : code_r + 4'h1;
    assign frames_nxt = dwell_done ? BPG_ZERO : frames_r + 8'h01;
    assign code = code_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            code_r <= BPG_AUTO_FIRST;
            frames_r <= BPG_ZERO;
        end else if (!enable) begin
            code_r <= BPG_AUTO_FIRST;
            frames_r <= BPG_ZERO;
        end else if (frame_start) begin
            frames_r <= frames_nxt;
            if (dwell_done) begin
                code_r <= code_nxt;
            end
        end
    end

    chk_auto_range: assert property (@(posedge clk) disable iff (rst)
        code_r <= BPG_AUTO_LAST) else $error("auto code out of range");
    chk_auto_wrap: assert property (@(posedge clk) disable iff (rst)
        enable && frame_start && dwell_done && code_r == BPG_AUTO_LAST
        |=> code_r == BPG_AUTO_FIRST) else $error("auto run did not wrap");
    chk_auto_step: assert property (@(posedge clk) disable iff (rst)
        enable && frame_start && dwell_done && code_r < BPG_AUTO_LAST
        |=> code_r == $past(code_r) + 4'h1) else $error("auto step wrong");
    cov_auto_wrap: cover property (@(posedge clk) disable iff (rst)
        code_r == BPG_AUTO_LAST ##1 code_r == BPG_AUTO_FIRST);
endmodule
`default_nettype wire

/* verif/bpg_panel_model.sv */
// Panel timing model: raster positions, data enable and frame pulse.
// Assumes rst is released by the bench and the active size is static.
`timescale 1ns/10ps
`default_nettype none
module bpg_panel_model
    import bpg_pkg::*;
#(
    parameter int H_BLANK = 2
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Active size
    input wire logic [COORD_W-1:0] h_active,
    input wire logic [COORD_W-1:0] v_active,
    // Raster out
    output logic [COORD_W-1:0] pix_x,
    output logic [COORD_W-1:0] pix_y,
    output logic pix_de,
    output logic frame_start
);
    // =========================================
    // Raster stepping
    // Blank positions toggle so stale values never pass as valid
    task automatic step(input logic de, input int x, input int y,
                        input logic fs);
        @(posedge clk);
        #1;
        pix_de = de;
        frame_start = fs;
        pix_x = de ? COORD_W'(x) : ~pix_x;
        pix_y = de ? COORD_W'(y) : ~pix_y;
    endtask

    initial begin
        pix_x = '0;
        pix_y = '0;
        pix_de = 1'b0;
        frame_start = 1'b0;
        while (rst !== 1'b0) @(posedge clk);
        forever begin
            step(1'b0, 0, 0, 1'b1);
            repeat (2) step(1'b0, 0, 0, 1'b0);
            for (int y = 0; y < int'(v_active); y++) begin
                for (int x = 0; x < int'(h_active); x++) begin
                    step(1'b1, x, y, 1'b0);
                end
                repeat (H_BLANK) step(1'b0, 0, 0, 1'b0);
            end
        end
    end
endmodule
`default_nettype wire

/* verif/bpg_top_tb.sv */
// Self-checking bench for the pattern generator on an 8 by 8 raster.
// Assumes one cycle output latency and frame-paced auto run.
`timescale 1ns/10ps
`default_nettype none
module bpg_top_tb;
    import bpg_pkg::*;
    localparam logic [COORD_W-1:0] H = 12'h008;
    localparam logic [COORD_W-1:0] V = 12'h008;
    logic clk, rst, xc, de, fs, pde, pv, armed, par;
    logic [3:0] sel;
    logic [7:0] wlvl, pr, pg, pb;
    logic [COORD_W-1:0] px, py;
    logic [26:0] notes[$];
    logic [26:0] got;
    int errors, samples_checked, seed, acnt;

    bpg_top i_dut (.clk(clk), .rst(rst), .test_pattern_select(sel),
        .white_field_level(wlvl), .crosstalk_center_colour(xc),
        .h_active(H), .v_active(V), .pix_x(px), .pix_y(py), .pix_de(de),
        .frame_start(fs), .pat_r(pr), .pat_g(pg), .pat_b(pb),
        .pat_de(pde), .pat_valid(pv));
    assign got = {pv, pde, pr, pg, pb};
    bpg_panel_model i_panel (.clk(clk), .rst(rst), .h_active(H),
        .v_active(V), .pix_x(px), .pix_y(py), .pix_de(de), .frame_start(fs));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // =========================================
    // Expected pixel: {valid, de, r, g, b}
    function automatic logic [26:0] want(input logic [3:0] c,
            input logic [COORD_W-1:0] x, input logic [COORD_W-1:0] y,
            input logic d);
        logic [7:0] k;
        logic [2:0] m;
        logic inb;
        logic [COORD_W-1:0] cx, cy;
        m = 3'b111;
        k = 8'h00;
        cx = x / (H / 8);
        cy = y / (V / 8);
        inb = x >= H / 4 && x < H - H / 4 && y >= V / 4 && y < V - V / 4;
        case (c)
            4'h0: k = wlvl;
            4'h2: begin k = 8'hFF; m = 3'b100; end
            4'h3: begin k = 8'hFF; m = 3'b010; end
            4'h4: begin k = 8'hFF; m = 3'b001; end
            4'h5: k = {8{cx[0] ^ cy[0]}};
            4'h6: k = 8'((int'(x) * 256) / int'(H));
            4'h7: k = 8'((int'(y) * 256) / int'(V));
            4'h8: k = 8'hC0;
            4'h9: k = {8{~(inb ^ xc)}};
            4'hA: k = {8{~y[0]}};
            4'hB: k = {8{~x[0]}};
            4'hC: k = {8{par ^ x[0] ^ y[0]}};
            default: k = 8'h00;
        endcase
        if (!d) k = 8'h00;
        return {c != 4'hD && c != 4'hF, d, m[2] ? k : 8'h00,
                m[1] ? k : 8'h00, m[0] ? k : 8'h00};
    endfunction

    // Driver side notes each expectation as the design samples it
    always @(posedge clk) begin
        if (rst) begin
            par = 1'b0;
            acnt = 0;
            notes.delete();
            armed <= 1'b0;
        end else begin
            if (sel != 4'hE) acnt = 0;
            else if (fs) acnt++;
            if (fs) par = ~par;
            notes.push_back(want(sel != 4'hE ? sel
                : 4'((acnt / int'(BPG_AUTO_FRAMES))
                % (int'(BPG_AUTO_LAST) + 1)), px, py, de));
            armed <= 1'b1;
        end
    end

    task automatic cmp(input logic [26:0] got, input logic [26:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Monitor takes the oldest note, one result per cycle
    always @(posedge clk) begin
        if (!rst && armed && notes.size() > 0)
            cmp(got, notes.pop_front());
    end

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wait_frame();
        int n;
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit && n < 500) begin
            @(posedge clk);
            hit = fs === 1'b1;
            n++;
        end
        #1;
        if (!hit) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            give_verdict();
        end
    endtask

    // =========================================
    // Main sequence
    initial begin
        seed = 81978;
        rst = 1'b1;
        sel = 4'h1;
        wlvl = 8'h00;
        xc = 1'b0;
        errors = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        // Each fixed and reserved code over a whole frame, with code D run in place of auto run
        for (int i = 0; i < 32; i++) begin
            wait_frame();
            sel = 4'(i % 16);
            if (sel == 4'hE) sel = 4'hD;
            wlvl = 8'($random(seed));
            xc = i >= 16;
        end
        wait_frame();
        $display("test all codes done");
        // Select and settings change on every cycle
        repeat (400) begin
            sel = 4'($random(seed));
            if (sel == 4'hE) sel = 4'h0;
            wlvl = 8'($random(seed));
            xc = 1'($random(seed));
            @(posedge clk);
            #1;
        end
        $display("test random select done");
        // Auto run through a full cycle and past the wrap
        wait_frame();
        sel = 4'hE;
        repeat (13 * 60 + 65) wait_frame();
        $display("test auto run done");
        give_verdict();
    end
endmodule
`default_nettype wire
